// ---- hw/pchdr_defs.svh ----
// Offsets, field values, reset values and timing figures of the configuration header bank
`ifndef PCHDR_DEFS_SVH
`define PCHDR_DEFS_SVH
`define PCHDR_OFS_IDENT 7'h00
`define PCHDR_OFS_STATCMD 7'h04
`define PCHDR_OFS_CLASSREV 7'h08
`define PCHDR_OFS_MISC 7'h0C
`define PCHDR_OFS_BASE0 7'h10
`define PCHDR_OFS_BASE1 7'h14
`define PCHDR_OFS_BASE2 7'h18
`define PCHDR_OFS_BASE3 7'h1C
`define PCHDR_OFS_BASE4 7'h20
`define PCHDR_OFS_BASE5 7'h24
`define PCHDR_OFS_W28 7'h28
`define PCHDR_OFS_W2C 7'h2C
`define PCHDR_OFS_W30 7'h30
`define PCHDR_OFS_CAPLIST 7'h34
`define PCHDR_OFS_W38 7'h38
`define PCHDR_OFS_INTR 7'h3C
`define PCHDR_OFS_MSGINT0 7'h40
`define PCHDR_OFS_MSGINT1 7'h44
`define PCHDR_OFS_MSGINT2 7'h48
`define PCHDR_OFS_MSGINT3 7'h4C
`define PCHDR_OFS_INFO 13'h1000
`define PCHDR_HDR_WORDS 5'd20
`define PCHDR_RST_VAL 32'h0000_0000
`define PCHDR_CMD_WMASK 32'h0000_0547
`define PCHDR_STAT_CAPLIST 32'h0010_0000
`define PCHDR_MSGINT_CAP_ID 8'h05
`define PCHDR_MSGINT_PTR 32'h0000_0040
`define PCHDR_EXT_BASE 12'h100
`define PCHDR_EXT_VER 4'h1
`define PCHDR_EXT_ID_SERIAL 16'h0003
`define PCHDR_EXT_ID_VC 16'h0002
`define PCHDR_EXT_ID_VENDOR 16'h000B
`define PCHDR_EXT_ID_ERR 16'h0001
`define PCHDR_EXT_ID_RESIZE 16'h0015
`define PCHDR_EXT_WORDS_SERIAL 10'd3
`define PCHDR_EXT_WORDS_VC 10'd7
`define PCHDR_EXT_WORDS_VENDOR 10'd6
`define PCHDR_EXT_WORDS_ERR 10'd14
`define PCHDR_EXT_WORDS_RESIZE 10'd13
`define PCHDR_RST_MIN_NS 1500
`define PCHDR_CLK_NS 50
`endif

// ---- hw/pchdr_pkg.sv ----
// Types shared by the configuration header bank
package pchdr_pkg;
  typedef logic [31:0] pchdr_word_t;
  typedef enum logic [1:0]
  {
    PCHDR_REF_100 = 2'b00,
    PCHDR_REF_125 = 2'b01,
    PCHDR_REF_250 = 2'b10,
    PCHDR_REF_BAD = 2'b11
  } pchdr_refclk_t;
  typedef enum logic [1:0]
  {
    PCHDR_RESP_OKAY = 2'b00,
    PCHDR_RESP_SLVERR = 2'b10
  } pchdr_resp_t;
endpackage

// ---- hw/pchdr_axil_slave.sv ----
// AXI4-Lite slave front end of the configuration header bank
`timescale 1ns/1ps
`default_nettype none
module pchdr_axil_slave #(
  parameter int ADDR_W = 13
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic blk_rst,
  // AXI4-Lite
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic aw_have_q;
  logic w_have_q;

  // Write fires only once the previous response has been taken
  assign wr_en = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge sys_clk)
  begin
    if (blk_rst)
    begin
      aw_have_q <= 1'b0;
      s_axi_awready <= 1'b0;
      wr_addr <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_q <= 1'b1;
      s_axi_awready <= 1'b0;
      wr_addr <= s_axi_awaddr;
    end
    else if (wr_en)
    begin
      aw_have_q <= 1'b0;
      s_axi_awready <= 1'b1;
    end
    else
      s_axi_awready <= !aw_have_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (blk_rst)
    begin
      w_have_q <= 1'b0;
      s_axi_wready <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_q <= 1'b1;
      s_axi_wready <= 1'b0;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end
    else if (wr_en)
    begin
      w_have_q <= 1'b0;
      s_axi_wready <= 1'b1;
    end
    else
      s_axi_wready <= !w_have_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (blk_rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pchdr_pkg::PCHDR_RESP_OKAY;
    end
    else if (wr_en)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_err ? pchdr_pkg::PCHDR_RESP_SLVERR : pchdr_pkg::PCHDR_RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read data is captured at the address handshake, so rdata holds still
  always_ff @(posedge sys_clk)
  begin
    if (blk_rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pchdr_pkg::PCHDR_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_err ? pchdr_pkg::PCHDR_RESP_SLVERR : pchdr_pkg::PCHDR_RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else
      s_axi_arready <= !s_axi_rvalid;
  end
endmodule // pchdr_axil_slave
`default_nettype wire

// ---- hw/pchdr_top.sv ----
// Configuration header register bank with hard reset handling, behind AXI4-Lite
// How it works
// R1 - The hard reset input is caught asynchronously and any pulse of it resets the whole block.
// R2 - The system holds hard reset for at least 1500 ns; the block also stretches it to that time.
// R3 - The platform's active-low reset is inverted outside, so hard reset here is active high.
// R4 - The reference clock is built for 100, 125 or 250 MHz and the supplied clock must match.
// R5 - In endpoint mode a reserved header word reads as all zeros.
// R6 - Extended capability headers are packed from 100h in order, only for the enabled set.
// R7 - The message signalled interrupt structure is sized by build options.
// R8 - Endpoint mode shows a 16-word Type 0 header with identity, status, class and interrupt.
// R9 - Type 0 has six base windows from 10h, then card pointer, ROM window and capability pointer.
// R10 - Bridge mode has only two base windows and bus numbers plus secondary latency at 18h.
// R11 - Type 1 holds I/O base, limit and secondary status at 1Ch and the upper I/O halves at 30h.
// R12 - Type 1 holds upper prefetchable base at 28h and upper prefetchable limit at 2Ch.
// R13 - Type 1 holds memory and prefetchable windows, each limit in the upper half.
// R14 - Reads to unimplemented configuration space complete successfully with zero data.
// R15 - Writes to read-only identity, class, revision and pointer fields change nothing.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "pchdr_defs.svh"
module pchdr_top #(
  parameter logic IS_BRIDGE = 1'b0,
  parameter int REFCLK_MHZ = 100,
  // Identity values are arbitrary
  parameter logic [15:0] VENDOR_CODE = 16'h1234,
  parameter logic [15:0] DEVICE_CODE = 16'h0001,
  parameter logic [31:0] SUBSYS_CODE = 32'h0001_1234,
  parameter logic [7:0] REVISION = 8'h00,
  parameter logic [23:0] CLASS_CODE = 24'h058000,
  parameter logic [5:0] BAR_EN = 6'h01,
  parameter int BAR_LOG2 = 12,
  parameter int ROM_LOG2 = 0,
  parameter logic [7:0] INTR_PIN = 8'h01,
  parameter logic MSGINT_64BIT = 1'b1,
  parameter logic [2:0] MSGINT_MMC = 3'h0,
  parameter logic [4:0] EXT_CAP_EN = 5'h1F,
  parameter int ADDR_W = 13
) (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hard_reset,
  // AXI4-Lite
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Decoded controls
  output logic io_decode_en,
  output logic mem_decode_en,
  output logic bus_master_en,
  output logic intx_disable,
  output logic message_signalled_interrupt_enable,
  output logic block_in_reset
);
  localparam int RST_CYC = (`PCHDR_RST_MIN_NS + `PCHDR_CLK_NS - 1) / `PCHDR_CLK_NS;
  localparam int RCW = $clog2(RST_CYC + 1);
  localparam logic [31:0] BAR_M = ~((32'h1 << BAR_LOG2) - 32'h1);
  localparam logic [31:0] ROM_M = (ROM_LOG2 == 0) ? 32'h0 : (~((32'h1 << ROM_LOG2) - 32'h1));

  logic [1:0] hrst_sync_q;
  logic [RCW-1:0] rst_cnt_q;
  logic blk_rst;
  pchdr_pkg::pchdr_word_t cfg_q [0:`PCHDR_HDR_WORDS-1];
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [31:0] rd_data;
  logic rd_err;

  // Active-high pulse from the inverted platform reset is caught without the clock
  always_ff @(posedge sys_clk or posedge hard_reset)
  begin
    if (hard_reset) // [R1] [R3]
      hrst_sync_q <= 2'b11;
    else
      hrst_sync_q <= {hrst_sync_q[0], 1'b0};
  end

  // Even a glitch of hard reset keeps the block down for the full minimum time
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || hrst_sync_q[1])
      rst_cnt_q <= '0;
    else if (rst_cnt_q != RCW'(RST_CYC)) // [R2]
      rst_cnt_q <= rst_cnt_q + RCW'(1);
  end

  assign blk_rst = !rst_n || hrst_sync_q[1] || (rst_cnt_q != RCW'(RST_CYC)); // [R1]

  always_ff @(posedge sys_clk)
  begin
    block_in_reset <= blk_rst;
  end

  function automatic pchdr_pkg::pchdr_refclk_t refclk_code(input int mhz);
    case (mhz) // [R4]
      100: return pchdr_pkg::PCHDR_REF_100;
      125: return pchdr_pkg::PCHDR_REF_125;
      250: return pchdr_pkg::PCHDR_REF_250;
      default: return pchdr_pkg::PCHDR_REF_BAD;
    endcase
  endfunction

  function automatic pchdr_pkg::pchdr_word_t bar_mask(input int n);
    return BAR_EN[n] ? BAR_M : 32'h0;
  endfunction

  // Writable bits of each header word; everything else ignores writes
  function automatic pchdr_pkg::pchdr_word_t hdr_mask(input logic [6:0] a);
    pchdr_pkg::pchdr_word_t m;
    m = 32'h0;
    case (a)
      `PCHDR_OFS_STATCMD: m = `PCHDR_CMD_WMASK;
      `PCHDR_OFS_MISC: m = 32'h0000_00FF;
      `PCHDR_OFS_BASE0: m = bar_mask(0); // [R9] [R10]
      `PCHDR_OFS_BASE1: m = bar_mask(1);
      `PCHDR_OFS_MSGINT0: m = 32'h0071_0000; // [R7]
      `PCHDR_OFS_MSGINT1: m = 32'hFFFF_FFFC;
      `PCHDR_OFS_MSGINT2: m = MSGINT_64BIT ? 32'hFFFF_FFFF : 32'h0000_FFFF;
      `PCHDR_OFS_MSGINT3: m = MSGINT_64BIT ? 32'h0000_FFFF : 32'h0;
      default:
      begin
        if (IS_BRIDGE)
        begin
          case (a)
            `PCHDR_OFS_BASE2: m = 32'hFFFF_FFFF; // [R10]
            `PCHDR_OFS_BASE3: m = 32'h0000_F0F0; // [R11]
            `PCHDR_OFS_BASE4: m = 32'hFFF0_FFF0; // [R13]
            `PCHDR_OFS_BASE5: m = 32'hFFF0_FFF0; // [R13]
            `PCHDR_OFS_W28: m = 32'hFFFF_FFFF; // [R12]
            `PCHDR_OFS_W2C: m = 32'hFFFF_FFFF; // [R12]
            `PCHDR_OFS_W30: m = 32'hFFFF_FFFF; // [R11]
            `PCHDR_OFS_W38: m = ROM_M | {31'h0, ROM_LOG2 != 0};
            `PCHDR_OFS_INTR: m = 32'h0FFF_00FF;
            default: m = 32'h0;
          endcase
        end
        else
        begin
          case (a)
            `PCHDR_OFS_BASE2: m = bar_mask(2); // [R9]
            `PCHDR_OFS_BASE3: m = bar_mask(3);
            `PCHDR_OFS_BASE4: m = bar_mask(4);
            `PCHDR_OFS_BASE5: m = bar_mask(5);
            `PCHDR_OFS_W30: m = ROM_M | {31'h0, ROM_LOG2 != 0};
            `PCHDR_OFS_INTR: m = 32'h0000_00FF; // [R8]
            default: m = 32'h0; // [R5] [R15]
          endcase
        end
      end
    endcase
    return m;
  endfunction

  // Constant bits of each header word
  function automatic pchdr_pkg::pchdr_word_t hdr_fixed(input logic [6:0] a);
    pchdr_pkg::pchdr_word_t f;
    f = 32'h0;
    case (a)
      `PCHDR_OFS_IDENT: f = {DEVICE_CODE, VENDOR_CODE}; // [R8] [R15]
      `PCHDR_OFS_STATCMD: f = `PCHDR_STAT_CAPLIST;
      `PCHDR_OFS_CLASSREV: f = {CLASS_CODE, REVISION}; // [R15]
      `PCHDR_OFS_MISC: f = {15'h0, IS_BRIDGE, 16'h0};
      `PCHDR_OFS_CAPLIST: f = `PCHDR_MSGINT_PTR; // [R15]
      `PCHDR_OFS_INTR: f = {16'h0, INTR_PIN, 8'h00};
      `PCHDR_OFS_MSGINT0: f = {8'h00, MSGINT_64BIT, 3'h0, MSGINT_MMC, 1'b0, 8'h00,
        `PCHDR_MSGINT_CAP_ID}; // [R7]
      default:
      begin
        if (IS_BRIDGE)
        begin
          case (a)
            `PCHDR_OFS_BASE3: f = 32'h0000_0101; // [R11]
            `PCHDR_OFS_BASE5: f = 32'h0001_0001; // [R13]
            default: f = 32'h0;
          endcase
        end
        else if (a == `PCHDR_OFS_W2C)
          f = SUBSYS_CODE; // [R8]
      end
    endcase
    return f;
  endfunction

  function automatic logic [9:0] ext_words(input int k);
    case (k)
      0: return `PCHDR_EXT_WORDS_SERIAL;
      1: return `PCHDR_EXT_WORDS_VC;
      2: return `PCHDR_EXT_WORDS_VENDOR;
      3: return `PCHDR_EXT_WORDS_ERR;
      default: return `PCHDR_EXT_WORDS_RESIZE;
    endcase
  endfunction

  function automatic logic [15:0] ext_id(input int k);
    case (k)
      0: return `PCHDR_EXT_ID_SERIAL;
      1: return `PCHDR_EXT_ID_VC;
      2: return `PCHDR_EXT_ID_VENDOR;
      3: return `PCHDR_EXT_ID_ERR;
      default: return `PCHDR_EXT_ID_RESIZE;
    endcase
  endfunction

  // Placement depends on the enabled set: disabled structures take no room
  function automatic logic [11:0] ext_base(input int k);
    logic [11:0] b;
    b = `PCHDR_EXT_BASE;
    for (int j = 0; j < k; j++)
    begin
      if (EXT_CAP_EN[j]) // [R6]
        b = b + {ext_words(j), 2'b00};
    end
    return b;
  endfunction

  function automatic logic [11:0] ext_next(input int k);
    logic [11:0] n;
    n = 12'h0;
    for (int j = 4; j > k; j--)
    begin
      if (EXT_CAP_EN[j])
        n = ext_base(j);
    end
    return n;
  endfunction

  function automatic pchdr_pkg::pchdr_word_t merge_bytes(
    input pchdr_pkg::pchdr_word_t old_v,
    input pchdr_pkg::pchdr_word_t new_v,
    input logic [3:0] strb,
    input pchdr_pkg::pchdr_word_t mask
  );
    pchdr_pkg::pchdr_word_t r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r & mask;
  endfunction

  // Only the header and interrupt structure hold state; read-only bits are never stored
  always_ff @(posedge sys_clk)
  begin
    if (blk_rst)
    begin
      for (int i = 0; i < `PCHDR_HDR_WORDS; i++)
        cfg_q[i] <= `PCHDR_RST_VAL;
    end
    else if (wr_en && (wr_addr[ADDR_W-1:7] == '0) && (wr_addr[6:2] < `PCHDR_HDR_WORDS))
    begin
      cfg_q[wr_addr[6:2]] <= merge_bytes(cfg_q[wr_addr[6:2]], wr_data, wr_strb,
        hdr_mask({wr_addr[6:2], 2'b00})); // [R15]
    end
  end

  // Config space and the info word accept writes; the rest of the bus space errors
  assign wr_err = (wr_addr[ADDR_W-1:12] != '0) && (wr_addr[ADDR_W-1:2] != `PCHDR_OFS_INFO >> 2);

  always_comb
  begin
    rd_data = 32'h0;
    rd_err = 1'b0;
    if (s_axi_araddr[ADDR_W-1:12] != '0)
    begin
      if (s_axi_araddr[ADDR_W-1:2] == `PCHDR_OFS_INFO >> 2)
        rd_data = {24'h0, EXT_CAP_EN, IS_BRIDGE, refclk_code(REFCLK_MHZ)}; // [R4]
      else
        rd_err = 1'b1;
    end
    else if (s_axi_araddr[11:7] == 5'h00)
    begin
      if (s_axi_araddr[6:2] < `PCHDR_HDR_WORDS)
        rd_data = (cfg_q[s_axi_araddr[6:2]] & hdr_mask({s_axi_araddr[6:2], 2'b00}))
          | hdr_fixed({s_axi_araddr[6:2], 2'b00}); // [R5] [R8]
    end
    else
    begin
      for (int k = 0; k < 5; k++)
      begin
        if (EXT_CAP_EN[k] && ({s_axi_araddr[11:2], 2'b00} == ext_base(k))) // [R6]
          rd_data = {ext_next(k), `PCHDR_EXT_VER, ext_id(k)};
      end
    end
    // Unmatched config-space addresses stay zero with an OKAY answer [R14]
  end

  assign io_decode_en = cfg_q[1][0];
  assign mem_decode_en = cfg_q[1][1];
  assign bus_master_en = cfg_q[1][2];
  assign intx_disable = cfg_q[1][10];
  assign message_signalled_interrupt_enable = cfg_q[16][16];

  pchdr_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_slave (
    .sys_clk(sys_clk),
    .blk_rst(blk_rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );
endmodule // pchdr_top
`default_nettype wire

// ---- verif/pchdr_monitor.sv ----
// Port checker for the configuration header bank
`timescale 1ns/1ps
`default_nettype none
module pchdr_monitor #(
  parameter logic IS_BRIDGE = 1'b0,
  parameter int ADDR_W = 13
) (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hard_reset,
  // AXI4-Lite
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Decoded controls
  input wire logic io_decode_en,
  input wire logic mem_decode_en,
  input wire logic bus_master_en,
  input wire logic intx_disable,
  input wire logic message_signalled_interrupt_enable,
  input wire logic block_in_reset
);
  logic [ADDR_W-1:0] aw_q;
  logic [ADDR_W-1:0] ar_q;
  logic [7:0] gone_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge sys_clk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      aw_q <= s_axi_awaddr;
    if (s_axi_arvalid && s_axi_arready)
      ar_q <= s_axi_araddr;
  end
  // Saturating count since both resets went away
  always_ff @(posedge sys_clk)
  begin
    if (hard_reset || !rst_n)
      gone_q <= 8'h00;
    else if (gone_q != 8'hFF)
      gone_q <= gone_q + 8'h01;
  end
  sequence s_wr_take(logic [10:0] idx);
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awaddr[12:2] == idx && s_axi_wstrb == 4'hF;
  endsequence
  sequence s_rd_at(logic [10:0] idx);
    s_axi_rvalid && ar_q[12:2] == idx;
  endsequence
  AST_HARD_ENTER: assert property ($rose(hard_reset) |-> ##[1:4] block_in_reset)
    else $error("hard reset did not reach the bank");
  AST_RST_QUIET: assert property (block_in_reset |-> !s_axi_awready && !s_axi_wready
    && !s_axi_arready && !s_axi_bvalid && !s_axi_rvalid && !io_decode_en
    && !mem_decode_en && !message_signalled_interrupt_enable)
    else $error("bank active while in reset");
  AST_STRETCH: assert property ($fell(block_in_reset) |-> gone_q >= 8'd29)
    else $error("reset released too early");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer timing wrong");
  AST_WR_RESP: assert property (s_axi_bvalid |->
    s_axi_bresp == ((aw_q > 13'h1003) ? 2'b10 : 2'b00))
    else $error("write response code wrong");
  AST_EXT_ZERO: assert property (s_axi_rvalid && ar_q >= 13'h01AC && ar_q < 13'h1000
    |-> s_axi_rdata == 32'h0000_0000 && s_axi_rresp == 2'b00)
    else $error("unimplemented space not zero");
  AST_RSVD_ZERO: assert property (s_rd_at(11'h00E) |-> IS_BRIDGE || s_axi_rdata == 32'h0)
    else $error("reserved word not zero");
  AST_CMD_OUT: assert property (s_wr_take(11'h001) |-> ##3
    io_decode_en == $past(s_axi_wdata[0], 3) && mem_decode_en == $past(s_axi_wdata[1], 3)
    && bus_master_en == $past(s_axi_wdata[2], 3) && intx_disable == $past(s_axi_wdata[10], 3))
    else $error("command outputs wrong");
  AST_MSI_OUT: assert property (s_wr_take(11'h010) |-> ##3
    message_signalled_interrupt_enable == $past(s_axi_wdata[16], 3))
    else $error("message interrupt enable wrong");
endmodule // pchdr_monitor
bind pchdr_top pchdr_monitor #(.IS_BRIDGE(IS_BRIDGE), .ADDR_W(ADDR_W)) u_monitor (.*);
`default_nettype wire

// ---- verif/pchdr_cfg_requester.sv ----
// Configuration requester model driving the bank over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module pchdr_cfg_requester (
  // Clock
  input wire logic sys_clk,
  // AXI4-Lite master side
  output logic [12:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [12:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  // Read data of the bridge build
  input wire logic [31:0] rdata_b
);
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  task automatic wr(input logic [12:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done = 1'b0;
    logic w_done = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge sys_clk);
      // Released lines show the inverse
      if (!aw_done && s_axi_awready)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (!w_done && s_axi_wready)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    do @(posedge sys_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [12:0] a, output logic [31:0] d, output logic [31:0] db,
    output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    db = rdata_b;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // pchdr_cfg_requester
`default_nettype wire

// ---- verif/test_pcie_config_header_and_sys_reset.sv ----
// Self-checking bench for the configuration header bank
`timescale 1ns/1ps
`default_nettype none
module test_pcie_config_header_and_sys_reset;
  logic sys_clk;
  logic rst_n;
  logic perst_n;
  wire hard_reset;
  wire [12:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata, rdata_b;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire io_decode_en, mem_decode_en, bus_master_en, intx_disable;
  wire message_signalled_interrupt_enable, block_in_reset;
  int n_fail = 0;
  int total_checks = 0;
  assign hard_reset = ~perst_n;
  pchdr_top dut (.*);
  // Bridge build shares the request lines
  pchdr_top #(.IS_BRIDGE(1'b1)) dut_bridge (.*, .s_axi_awready(), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(rdata_b), .s_axi_rresp(),
    .s_axi_rvalid(), .io_decode_en(), .mem_decode_en(), .bus_master_en(), .intx_disable(),
    .message_signalled_interrupt_enable(), .block_in_reset());
  pchdr_cfg_requester u_req (.*);
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while ((block_in_reset !== 1'b0 || s_axi_arready !== 1'b1) && n < 200)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk_word("ready after reset", 32'h1, {31'h0, s_axi_arready});
  endtask
  // Power-on reset
  task automatic t_reset;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (14) @(posedge sys_clk);
    perst_n <= 1'b1;
    wait_ready();
    $display("t_reset done");
  endtask
  // Write all ones to every header word, read both builds back
  task automatic t_header;
    logic [31:0] d, db;
    logic [1:0] r;
    logic [31:0] ep [20] = '{32'h0001_1234, 32'h0010_0547, 32'h0580_0000, 32'h0000_00FF,
      32'hFFFF_F000, 0, 0, 0, 0, 0, 0, 32'h0001_1234, 0, 32'h40, 0, 32'h0000_01FF,
      32'h00F1_0005, 32'hFFFF_FFFC, 32'hFFFF_FFFF, 32'h0000_FFFF};
    logic [31:0] br [20] = '{32'h0001_1234, 32'h0010_0547, 32'h0580_0000, 32'h0001_00FF,
      32'hFFFF_F000, 0, 32'hFFFF_FFFF, 32'h0000_F1F1, 32'hFFF0_FFF0, 32'hFFF1_FFF1,
      32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h40, 0, 32'h0FFF_01FF,
      32'h00F1_0005, 32'hFFFF_FFFC, 32'hFFFF_FFFF, 32'h0000_FFFF};
    for (int i = 0; i < 20; i++)
    begin
      u_req.wr(13'(i * 4), 32'hFFFF_FFFF, r);
      chk_resp($sformatf("bresp %h", i * 4), 2'b00, r);
      u_req.rd(13'(i * 4), d, db, r);
      chk_word($sformatf("endpoint %h", i * 4), ep[i], d);
      chk_word($sformatf("bridge %h", i * 4), br[i], db);
    end
    chk_word("decode outputs", 32'h1F, {27'h0, io_decode_en, mem_decode_en,
      bus_master_en, intx_disable, message_signalled_interrupt_enable});
    $display("t_header done");
  endtask
  // Extended space, info word, unmapped address
  task automatic t_ext;
    logic [31:0] d, db;
    logic [1:0] r;
    logic [12:0] ea [9] = '{13'h100, 13'h10C, 13'h128, 13'h140, 13'h178, 13'h1AC, 13'hFFC,
      13'h1000, 13'h1004};
    logic [31:0] ev [9] = '{32'h10C1_0003, 32'h1281_0002, 32'h1401_000B, 32'h1781_0001,
      32'h0001_0015, 0, 0, 32'hF8, 0};
    for (int i = 0; i < 9; i++)
    begin
      u_req.rd(ea[i], d, db, r);
      chk_word($sformatf("ext %h", ea[i]), ev[i], d);
      chk_word($sformatf("ext bridge %h", ea[i]), (i == 7) ? 32'hFC : ev[i], db);
      chk_resp($sformatf("rresp %h", ea[i]), (i == 8) ? 2'b10 : 2'b00, r);
    end
    u_req.wr(13'h1004, 32'h0, r);
    chk_resp("bresp unmapped", 2'b10, r);
    $display("t_ext done");
  endtask
  // Warm hard reset in mid-run clears both builds
  task automatic t_hard;
    logic [31:0] d, db;
    logic [1:0] r;
    @(posedge sys_clk);
    perst_n <= 1'b0;
    repeat (30) @(posedge sys_clk);
    chk_word("controls in reset", 32'h20, {26'h0, block_in_reset, io_decode_en,
      mem_decode_en, bus_master_en, intx_disable, message_signalled_interrupt_enable});
    perst_n <= 1'b1;
    wait_ready();
    u_req.rd(13'h004, d, db, r);
    chk_word("command after reset", 32'h0010_0000, d);
    u_req.rd(13'h018, d, db, r);
    chk_word("bus numbers after reset", 32'h0, db);
    $display("t_hard done");
  endtask
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    $display("[ERR] watchdog expected finish seen timeout");
    test_done();
  end
  initial
  begin
    rst_n = 1'b0;
    perst_n = 1'b0;
    t_reset();
    t_header();
    t_ext();
    t_hard();
    test_done();
  end
endmodule // test_pcie_config_header_and_sys_reset
`default_nettype wire
